// *** hdl/cisig_latency.sv ***
// Priority-resolution latency counter for the request lines
`timescale 1ns/1ps
module cisig_latency (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic restart_i,
  input wire logic [3:0] hpl_i,
  // Status
  output logic done_o
);
  import cisig_pkg::*;

  logic [3:0] cnt_q, cnt_d;
  logic run_q, run_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_o = 1'b0;
    if (restart_i) begin
      cnt_d = 4'h1;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q >= hpl_i) begin
        done_o = 1'b1;
        run_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end
endmodule : cisig_latency

// *** hdl/cisig_pkg.sv ***
// Package of constants for the cpu interrupt signaling block
package cisig_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_IRQ = 8;
  localparam int ID_W = 3;
  localparam int PRIO_W = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int HPL_MIN_CYC = 1;
  localparam int HPL_MAX_CYC = 10;
  localparam logic [3:0] HPL_RESET = 4'h2;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] ACK_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] EOI_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] ACTIVE_OFS = 4'h3;
  localparam logic [ADDR_W-1:0] PEND_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] SECURE_OFS = 4'h5;
  localparam logic [ADDR_W-1:0] IEN_OFS = 4'h6;
  localparam logic [ADDR_W-1:0] PRIO_LO_OFS = 4'h7;
  localparam logic [ADDR_W-1:0] PRIO_HI_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] EVT_STAT_OFS = 4'h9;
  localparam logic [ADDR_W-1:0] EVT_CLR_OFS = 4'hA;
  localparam logic [ADDR_W-1:0] EVT_EN_OFS = 4'hB;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SPLIT_BIT = 1;
  localparam int CTRL_HPL_LSB = 4;
  localparam int ACK_VALID_BIT = 31;
  localparam logic [ID_W-1:0] SPURIOUS_ID = 3'h0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000021;
  localparam logic [DATA_W-1:0] PRIO_RESET = 32'h00000000;
  localparam int EVT_ACK_BIT = 0;
  localparam int EVT_EOI_BIT = 1;
  localparam int EVT_PREEMPT_BIT = 2;
  localparam int EVT_W = 3;
endpackage : cisig_pkg

// *** hdl/cisig_top.sv ***
// Interrupt signaling core: pending/active tracking and request lines
// ---------------------------------------------------------------
// Summary of operation
// - Single-security build sends secure interrupts on the normal line.
// - Normal line driven low until acknowledge read or secure pre-emption.
// - Input rise marks the interrupt pending on a following cycle.
// - Line asserts a configured latency (1 to 10 cycles) after pending.
// - New pending interrupt during latency restarts the count.
// - Higher-priority arrival pre-empts lower one next cycle.
// - Pre-emption loads acknowledge identifier with new winner.
// - Acknowledge read deasserts the asserted request line.
// - Acknowledge moves interrupt to active and sets its active bit.
// - End of interrupt returns it inactive, clears active bit.
// - After completion, next pending asserts after the latency.
// - Control bit picks all-normal or split secure-fast routing.
// - Split mode drives the matching line; fast held until acknowledge.
// - Normal line released the cycle after acknowledge, or when a secure pre-emption asserts the fast line.
// ---------------------------------------------------------------
`timescale 1ns/1ps
module cisig_top #(
  parameter bit SECURITY_SUPPORT = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Peripheral interrupt inputs
  input wire logic [cisig_pkg::NUM_IRQ-1:0] irq_i,
  // Register port
  input wire logic [cisig_pkg::ADDR_W-1:0] addr_i,
  input wire logic [cisig_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [cisig_pkg::DATA_W-1:0] rdata_o,
  // Processor request lines
  output logic irq_n_o,
  output logic fiq_n_o,
  // Event interrupt
  output logic evt_irq_o
);
  import cisig_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [ID_W:0] find_best(input logic [NUM_IRQ-1:0] cand,
                                              input logic [2*DATA_W-1:0] prio);
    logic [ID_W:0] best;
    logic [PRIO_W-1:0] bp;
    best = {1'b0, SPURIOUS_ID};
    bp = '1;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (cand[i] && (!best[ID_W] || prio[i*PRIO_W +: PRIO_W] < bp)) begin
        best = {1'b1, ID_W'(i)};
        bp = prio[i*PRIO_W +: PRIO_W];
      end
    end
    return best;
  endfunction : find_best

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    return a == o;
  endfunction : hit

  function automatic logic [PRIO_W-1:0] prio_of(input logic [ID_W-1:0] id,
                                                input logic [2*DATA_W-1:0] prio);
    return prio[id*PRIO_W +: PRIO_W];
  endfunction : prio_of

  // ---------------------------------------------------------------
  // Input synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [NUM_IRQ-1:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= irq_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic [NUM_IRQ-1:0] rise;
  assign rise = s2_q & ~s3_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_q, ctrl_d, prio_lo_q, prio_lo_d, prio_hi_q, prio_hi_d;
  logic [NUM_IRQ-1:0] sec_q, sec_d, ien_q, ien_d;
  logic [NUM_IRQ-1:0] pend_q, pend_d, act_q, act_d;
  logic [ID_W-1:0] ack_id_q, ack_id_d;
  logic ack_vld_q, ack_vld_d;
  logic [ID_W:0] owner_q, owner_d;
  logic irq_n_q, irq_n_d, fiq_n_q, fiq_n_d;
  logic [EVT_W-1:0] evt_q, evt_d, evt_en_q, evt_en_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  logic split, enable;
  logic [3:0] hpl;
  assign enable = ctrl_q[CTRL_EN_BIT];
  assign split = SECURITY_SUPPORT && ctrl_q[CTRL_SPLIT_BIT];
  assign hpl = (ctrl_q[CTRL_HPL_LSB +: 4] < 4'(HPL_MIN_CYC)) ? 4'(HPL_MIN_CYC) :
               (ctrl_q[CTRL_HPL_LSB +: 4] > 4'(HPL_MAX_CYC)) ? 4'(HPL_MAX_CYC) :
               ctrl_q[CTRL_HPL_LSB +: 4];

  logic ack_rd, eoi_wr;
  assign ack_rd = rd_i && hit(addr_i, ACK_OFS);
  assign eoi_wr = wr_i && hit(addr_i, EOI_OFS);

  // Winner from next-cycle view; lower priority waits while one is active
  logic [ID_W:0] best, cand_best, run_best;
  logic new_pend, lat_done, restart;
  logic [2*DATA_W-1:0] prio_all;
  logic [NUM_IRQ-1:0] pend_nx, act_nx;
  assign prio_all = {prio_hi_q, prio_lo_q};
  assign pend_nx = pend_q | (rise & ien_q);
  assign act_nx = eoi_wr ? (act_q & ~(NUM_IRQ'(1) << wdata_i[ID_W-1:0])) : act_q;
  assign cand_best = find_best(pend_nx & ~act_nx & ien_q, prio_all);
  assign run_best = find_best(act_nx, prio_all);
  assign best = (run_best[ID_W] && prio_of(cand_best[ID_W-1:0], prio_all) >=
                 prio_of(run_best[ID_W-1:0], prio_all)) ? {1'b0, SPURIOUS_ID} :
                cand_best;
  assign new_pend = |(rise & ien_q & ~pend_q);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    prio_lo_d = prio_lo_q;
    prio_hi_d = prio_hi_q;
    sec_d = sec_q;
    ien_d = ien_q;
    evt_en_d = evt_en_q;
    pend_d = pend_q | (rise & ien_q);
    act_d = act_q;
    ack_id_d = ack_id_q;
    ack_vld_d = ack_vld_q;
    owner_d = owner_q;
    irq_n_d = irq_n_q;
    fiq_n_d = fiq_n_q;
    evt_d = evt_q;
    restart = 1'b0;
    if (wr_i) begin
      case (addr_i)
        CTRL_OFS: ctrl_d = wdata_i;
        SECURE_OFS: sec_d = wdata_i[NUM_IRQ-1:0];
        IEN_OFS: ien_d = wdata_i[NUM_IRQ-1:0];
        PRIO_LO_OFS: prio_lo_d = wdata_i;
        PRIO_HI_OFS: prio_hi_d = wdata_i;
        EVT_CLR_OFS: evt_d = evt_d & ~wdata_i[EVT_W-1:0];
        EVT_EN_OFS: evt_en_d = wdata_i[EVT_W-1:0];
        default: ;
      endcase
    end
    // Pre-emption: new winner updates the identifier next cycle
    if (best[ID_W] && best != owner_q) begin
      owner_d = best;
      ack_id_d = best[ID_W-1:0];
      ack_vld_d = 1'b1;
      restart = 1'b1;
      if (owner_q[ID_W]) begin
        evt_d[EVT_PREEMPT_BIT] = 1'b1;
      end
    end else if (!best[ID_W]) begin
      owner_d = {1'b0, SPURIOUS_ID};
      ack_vld_d = 1'b0;
    end
    if (new_pend && best[ID_W]) begin
      restart = 1'b1;
    end
    // Latency expiry drives the line for the current winner
    if (lat_done && owner_q[ID_W] && enable && !ack_rd) begin
      if (split && sec_q[owner_q[ID_W-1:0]]) begin
        fiq_n_d = 1'b0;
        irq_n_d = 1'b1;
      end else begin
        irq_n_d = 1'b0;
        fiq_n_d = fiq_n_q;
      end
    end
    // Acknowledge read
    if (ack_rd) begin
      irq_n_d = 1'b1;
      fiq_n_d = 1'b1;
      evt_d[EVT_ACK_BIT] = 1'b1;
      if (owner_q[ID_W]) begin
        act_d[owner_q[ID_W-1:0]] = 1'b1;
        pend_d[owner_q[ID_W-1:0]] = 1'b0;
        owner_d = {1'b0, SPURIOUS_ID};
        ack_vld_d = 1'b0;
      end
    end
    // End of interrupt, processor gives the serviced identifier
    if (eoi_wr) begin
      act_d[wdata_i[ID_W-1:0]] = 1'b0;
      evt_d[EVT_EOI_BIT] = 1'b1;
    end
    if (!enable) begin
      irq_n_d = 1'b1;
      fiq_n_d = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Latency counter
  // ---------------------------------------------------------------
  cisig_latency u_lat (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart),
    .hpl_i(hpl),
    .done_o(lat_done)
  );

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      case (addr_i)
        CTRL_OFS: rdata_d = ctrl_q;
        ACK_OFS: begin
          rdata_d[ID_W-1:0] = ack_id_q;
          rdata_d[ACK_VALID_BIT] = ack_vld_q;
        end
        ACTIVE_OFS: rdata_d[NUM_IRQ-1:0] = act_q;
        PEND_OFS: rdata_d[NUM_IRQ-1:0] = pend_q;
        SECURE_OFS: rdata_d[NUM_IRQ-1:0] = sec_q;
        IEN_OFS: rdata_d[NUM_IRQ-1:0] = ien_q;
        PRIO_LO_OFS: rdata_d = prio_lo_q;
        PRIO_HI_OFS: rdata_d = prio_hi_q;
        EVT_STAT_OFS: rdata_d[EVT_W-1:0] = evt_q;
        EVT_EN_OFS: rdata_d[EVT_W-1:0] = evt_en_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      prio_lo_q <= PRIO_RESET;
      prio_hi_q <= PRIO_RESET;
      sec_q <= '0;
      ien_q <= '1;
      evt_en_q <= '0;
      pend_q <= '0;
      act_q <= '0;
      ack_id_q <= SPURIOUS_ID;
      ack_vld_q <= 1'b0;
      owner_q <= '0;
      irq_n_q <= 1'b1;
      fiq_n_q <= 1'b1;
      evt_q <= '0;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      prio_lo_q <= prio_lo_d;
      prio_hi_q <= prio_hi_d;
      sec_q <= sec_d;
      ien_q <= ien_d;
      evt_en_q <= evt_en_d;
      pend_q <= pend_d;
      act_q <= act_d;
      ack_id_q <= ack_id_d;
      ack_vld_q <= ack_vld_d;
      owner_q <= owner_d;
      irq_n_q <= irq_n_d;
      fiq_n_q <= fiq_n_d;
      evt_q <= evt_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign irq_n_o = irq_n_q;
  assign fiq_n_o = fiq_n_q;
  assign evt_irq_o = |(evt_q & evt_en_q);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ack_releases: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_rd |=> irq_n_o && fiq_n_o)
    else $error("request line not released after acknowledge");
  a_ack_activates: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_rd && owner_q[ID_W] |=> act_q[$past(owner_q[ID_W-1:0])])
    else $error("acknowledged interrupt not active");
  a_eoi_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    eoi_wr && !ack_rd |=> !act_q[$past(wdata_i[ID_W-1:0])])
    else $error("active bit not cleared by end of interrupt");
  a_fiq_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !fiq_n_o && !ack_rd && enable |=> !fiq_n_o)
    else $error("fast line released without acknowledge");
  a_irq_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !irq_n_o && !ack_rd && enable && !lat_done |=> !irq_n_o)
    else $error("normal line released early");
  a_split_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
    !fiq_n_o |-> irq_n_o)
    else $error("both lines low in split mode");
  a_single_normal: assert property (@(posedge clk_i) disable iff (rst_i)
    !split && !$past(split) |-> fiq_n_o)
    else $error("fast line used without split mode");
  a_preempt_id: assert property (@(posedge clk_i) disable iff (rst_i)
    best[ID_W] && best != owner_q |=> ack_id_q == $past(best[ID_W-1:0]))
    else $error("identifier not updated on pre-emption");
  a_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    restart |=> ##[0:10] (lat_done || restart))
    else $error("latency exceeded");
  a_pend_mark: assert property (@(posedge clk_i) disable iff (rst_i)
    |(rise & ien_q) |=> |(pend_q & $past(rise & ien_q)))
    else $error("rising input not marked pending");

  c_irq_assert: cover property (@(posedge clk_i) disable iff (rst_i) $fell(irq_n_o));
  c_fiq_assert: cover property (@(posedge clk_i) disable iff (rst_i) $fell(fiq_n_o));
  c_preempt: cover property (@(posedge clk_i) disable iff (rst_i)
    best[ID_W] && owner_q[ID_W] && best != owner_q);
  c_eoi: cover property (@(posedge clk_i) disable iff (rst_i) eoi_wr && |act_q);
endmodule : cisig_top

// *** test/cisig_cpu_model.sv ***
// Processor core model: acknowledge and completion accesses
`timescale 1ns/1ps
module cisig_cpu_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [cisig_pkg::ADDR_W-1:0] addr_o,
  output logic [cisig_pkg::DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [cisig_pkg::DATA_W-1:0] rdata_i
);
  import cisig_pkg::*;
  initial begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask : reg_rd
  // Service span, then completion with the serviced identifier
  task automatic complete(input logic [ID_W-1:0] id, input int span);
    repeat (span) @(posedge clk_i);
    reg_wr(EOI_OFS, {29'h00000000, id});
  endtask : complete
endmodule : cisig_cpu_model

// *** test/testbench.sv ***
// Self-checking testbench for the interrupt signaling core
`timescale 1ns/1ps
module testbench;
  import cisig_pkg::*;
  logic clk_i;
  logic rst_i;
  logic [NUM_IRQ-1:0] irq_i;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic wr;
  logic rd;
  logic irq_n_o;
  logic fiq_n_o;
  logic evt_irq_o;
  int fails;
  int check_count;
  int n;
  cisig_top dut (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_n_o(irq_n_o), .fiq_n_o(fiq_n_o),
    .evt_irq_o(evt_irq_o));
  cisig_cpu_model cpu (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic rchk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [DATA_W-1:0] v;
    cpu.reg_rd(a, v);
    check(name, v, exp);
  endtask : rchk
  task automatic cfg(input logic split, input logic [3:0] hpl);
    cpu.reg_wr(CTRL_OFS, {24'h000000, hpl, 2'b00, split, 1'b1});
  endtask : cfg
  task automatic raise(input int i);
    @(posedge clk_i);
    irq_i[i] <= 1'b1;
  endtask : raise
  // Edges until the chosen line is low, bounded
  task automatic wait_low(input bit fast);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while ((fast ? fiq_n_o : irq_n_o) !== 1'b0 && n < 40);
  endtask : wait_low
  task automatic ack(input logic [ID_W-1:0] id);
    logic [DATA_W-1:0] v;
    cpu.reg_rd(ACK_OFS, v);
    check("ack_id", {v[ACK_VALID_BIT], v[2:0]}, {1'b1, id});
    check("lines_after_ack", {irq_n_o, fiq_n_o}, 2'b11);
  endtask : ack
  task automatic svc(input int i);
    @(posedge clk_i);
    irq_i[i] <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    check("idle_in_service", {irq_n_o, fiq_n_o}, 2'b11);
    cpu.complete(ID_W'(i), 0);
  endtask : svc
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("lines_reset", {irq_n_o, fiq_n_o, evt_irq_o}, 3'b110);
    rchk("ctrl", CTRL_OFS, CTRL_RESET);
    rchk("ien", IEN_OFS, 32'h000000FF);
    rchk("prio", PRIO_LO_OFS, PRIO_RESET);
    rchk("unmapped", 4'hF, 32'h00000000);
  endtask : t_reset
  task automatic t_basic(input logic [3:0] hpl);
    cpu.reg_wr(EVT_EN_OFS, 32'h00000001);
    cfg(1'b0, hpl);
    raise(3);
    wait_low(1'b0);
    check("latency", n, hpl + 3);
    repeat (5) @(posedge clk_i);
    #1;
    check("held_low", irq_n_o, 1'b0);
    ack(3'h3);
    rchk("active", ACTIVE_OFS, 32'h00000008);
    rchk("pending", PEND_OFS, 32'h00000000);
    check("evt_on", evt_irq_o, 1'b1);
    cpu.reg_wr(EVT_EN_OFS, 32'h00000000);
    check("evt_masked", evt_irq_o, 1'b0);
    svc(3);
    rchk("inactive", ACTIVE_OFS, 32'h00000000);
    rchk("evt_stat", EVT_STAT_OFS, 32'h00000003);
    cpu.reg_wr(EVT_CLR_OFS, 32'h00000007);
    rchk("evt_clr", EVT_STAT_OFS, 32'h00000000);
  endtask : t_basic
  task automatic t_preempt();
    cpu.reg_wr(PRIO_LO_OFS, 32'h00000880);
    cpu.reg_wr(PRIO_HI_OFS, 32'h01000020);
    cfg(1'b0, 4'h2);
    raise(1);
    wait_low(1'b0);
    raise(5);
    repeat (12) begin
      @(posedge clk_i);
      #1;
      check("no_glitch", irq_n_o, 1'b0);
    end
    ack(3'h5);
    rchk("evt_preempt", EVT_STAT_OFS, 32'h00000005);
    svc(5);
    wait_low(1'b0);
    check("next_latency", n, 32'd2);
    ack(3'h1);
    svc(1);
    raise(1);
    @(posedge clk_i);
    raise(5);
    wait_low(1'b0);
    check("restart", n, 32'd5);
    ack(3'h5);
    svc(5);
    wait_low(1'b0);
    check("resume_latency", n, 32'd2);
    ack(3'h1);
    svc(1);
  endtask : t_preempt
  task automatic t_split();
    cpu.reg_wr(SECURE_OFS, 32'h00000040);
    cfg(1'b0, 4'h3);
    raise(6);
    wait_low(1'b0);
    check("secure_on_normal", {n[7:0], fiq_n_o}, {8'd6, 1'b1});
    ack(3'h6);
    svc(6);
    cfg(1'b1, 4'h3);
    raise(2);
    wait_low(1'b0);
    check("split_normal", {n[7:0], fiq_n_o}, {8'd6, 1'b1});
    raise(6);
    wait_low(1'b1);
    check("fast_latency", n, 32'd6);
    check("normal_released", irq_n_o, 1'b1);
    repeat (5) @(posedge clk_i);
    #1;
    check("fast_held", fiq_n_o, 1'b0);
    ack(3'h6);
    svc(6);
    wait_low(1'b0);
    check("back_to_normal", n, 32'd3);
    ack(3'h2);
    svc(2);
  endtask : t_split
  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    irq_i = '0;
    fails = 0;
    check_count = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset();
    t_basic(4'h1);
    t_basic(4'hA);
    t_preempt();
    t_split();
    stop_test();
  end
  initial begin
    #(20000 * CLK_PERIOD_NS);
    fails++;
    stop_test();
  end
endmodule : testbench
